// ==== dopc_ctrl.sv ====
/*
  Digital output protection controller: internal and external drive sequencing,
  two-stage short-circuit timing, thermal shutdown, alert flags, diagnostic slot
  routing and an Avalon-MM register slave.
  Assumes comparator and pin inputs are asynchronous and the diagnostic results
  arrive on the core clock.
*/
`timescale 1ns/1ps

// Contract
// (R01) Smart-diode source mode drives the diode gate to switch the series FET on.
// (R02) Internal mode selects disabled, source, sink or push-pull; push-pull uses both FETs.
// (R03) Source-select bit picks serial data bit or control pin as output level.
// (R04) Push-pull never uses the high-current phase, internal or external.
// (R05) Serial bit 1 turns the FET on; in push-pull 0 drives low, 1 high.
// (R06) Host sets the data bit in a later write after configuring.
// (R07) Second pin config 0x0004 hands internal level to its control pin.
// (R08) Host disables the mode before changing to another drive kind.
// (R09) Enabled internal output has thermal shutdown; overheating sets its flag.
// (R10) Internal output switches back on once cooled to re-enable point.
// (R11) External short sets the external short flag and the alert pin.
// (R12) Internal short sets the internal short flag and the alert pin.
// (R13) T1 starts when the FET is switched on, short or not.
// (R14) Short during T1 keeps FET on at high limit, no alert.
// (R15) T2 starts after T1 only on a short; FET stays on at low limit.
// (R16) Short persisting at end of T2 disables FET and sets timeout flag.
// (R17) Timeout disable shows as disabled mode in the configuration readback.
// (R18) T1 and T2 programmable per output; T1 code zero bypasses T1.
// (R19) Host recovers by clearing data, rewriting mode, then setting data.
// (R20) External current sense: slot 0 sinking, slot 1 sourcing.
// (R21) Host enables slot 0 whenever slot 1 senses external sourcing.
// (R22) Internal current sense: slot 2 sinking, slot 3 sourcing; results readable.
// (R23) Host enables slot 2 whenever slot 3 senses internal sourcing.
// (R24) External mode selects source, sink, push-pull or disabled.
// (R25) First pin config 0x0004 hands external level to its control pin.
// (R26) Per-output state machine off, T1, normal, T2, timed-out with decoded counts.
// (R27) Alert flags stay until written one; alert pin active while any set.
module dopc_ctrl #(
  parameter int T_UNIT_CYC = dopc_pkg::T_UNIT_CYC
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [5:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  input  wire logic [3:0]  i_byteenable,
  output logic      [31:0] o_readdata,
  output logic             o_waitrequest,
  input  wire logic        i_int_ctrl_pin,
  input  wire logic        i_ext_ctrl_pin,
  input  wire logic        i_int_short,
  input  wire logic        i_ext_short,
  input  wire logic        i_therm_hot,
  input  wire logic        i_therm_cool,
  input  wire logic [63:0] i_diag_result,
  output logic             o_int_src_on,
  output logic             o_int_snk_on,
  output logic             o_int_hi_limit,
  output logic             o_ext_src_on,
  output logic             o_ext_snk_on,
  output logic             o_ext_hi_limit,
  output logic             o_smart_diode_gate,
  output logic             o_alert_n,
  output logic [3:0]       o_diag_cur_sense
);

  // Longest low-limit time must fit the 16-bit protection timer
  if (T_UNIT_CYC < 1 || T_UNIT_CYC * 8 > 65535) begin : g_bad_unit
    $error("dopc_ctrl: T_UNIT_CYC out of range");
  end

  // Two-stage synchronisers for pins and analog comparators
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
    end else begin
      sync1_r <= {i_therm_cool, i_therm_hot, i_ext_short, i_int_short, i_ext_ctrl_pin, i_int_ctrl_pin};
      sync2_r <= sync1_r;
    end
  end
  wire logic [1:0] pin_s   = sync2_r[1:0];
  wire logic [1:0] short_s = sync2_r[3:2];
  wire logic       hot_s   = sync2_r[4];
  wire logic       cool_s  = sync2_r[5];

  // Bus handshake: one wait cycle, then the access completes
  logic        wait_r;
  logic [31:0] rdata_r;
  wire  logic  req    = i_read | i_write;
  wire  logic  wr_go  = i_write & ~wait_r;
  wire  logic [15:0] bmask = {{8{i_byteenable[1]}}, {8{i_byteenable[0]}}};

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw, input logic [15:0] m);
    merge16 = (old & ~m) | (nw & m);
  endfunction

  // Software registers
  logic [dopc_pkg::CFG_W-1:0]   cfg_r [2];
  logic [15:0]                  pin_cfg_r [2];
  logic [dopc_pkg::ALERT_W-1:0] alert_r;
  logic [15:0]                  diag_sel_r;
  logic [15:0]                  conv_ctrl_r;
  logic                         therm_off_r;
  dopc_pkg::dopc_state_e        st_r [2];

  wire logic [1:0] wr_cfg = {wr_go & (i_address == dopc_pkg::ADDR_EXT_CFG),
                             wr_go & (i_address == dopc_pkg::ADDR_INT_CFG)};
  wire logic [1:0] wr_pin = {wr_go & (i_address == dopc_pkg::ADDR_PIN_CFG1),
                             wr_go & (i_address == dopc_pkg::ADDR_PIN_CFG2)};
  wire logic wr_alert = wr_go & (i_address == dopc_pkg::ADDR_ALERT);
  wire logic wr_diag  = wr_go & (i_address == dopc_pkg::ADDR_DIAG_SEL);
  wire logic wr_conv  = wr_go & (i_address == dopc_pkg::ADDR_CONV_CTRL);

  // Per-output events and drive flops
  logic [1:0] short_ev;
  logic [1:0] tout_ev;
  logic [3:0] drv_r [2];
  logic [1:0] int_en_w;
  wire  logic int_en    = int_en_w[0];
  wire  logic therm_ev  = int_en & hot_s & ~therm_off_r;

  // Channel 0 is the internal drive, channel 1 the external drive
  for (genvar ch = 0; ch < 2; ch++) begin : g_out
    wire logic [2:0] mode = cfg_r[ch][dopc_pkg::CFG_MODE_LSB +: dopc_pkg::CFG_MODE_W];
    wire logic [2:0] t1   = cfg_r[ch][dopc_pkg::CFG_T1_LSB +: dopc_pkg::CFG_T_W];
    wire logic [2:0] t2   = cfg_r[ch][dopc_pkg::CFG_T2_LSB +: dopc_pkg::CFG_T_W];
    wire logic pin_ok  = (pin_cfg_r[ch] == dopc_pkg::PIN_CFG_LEVEL);   // see (R07) (R25)
    wire logic [15:0] cfg_wr = merge16(16'(cfg_r[ch]), i_writedata[15:0], bmask);
    wire logic level   = cfg_r[ch][dopc_pkg::CFG_SRC_BIT] ? (pin_ok & pin_s[ch])
                                                           : cfg_r[ch][dopc_pkg::CFG_DATA_BIT]; // see (R03)
    wire logic is_pp   = (mode == dopc_pkg::MODE_PP);
    wire logic is_srcd = (ch == 1) && (mode == dopc_pkg::MODE_SRC_D);
    wire logic is_src  = (mode == dopc_pkg::MODE_SRC) | is_srcd;
    wire logic is_snk  = (mode == dopc_pkg::MODE_SNK);
    wire logic en      = is_pp | is_src | is_snk;               // see (R02) (R24)
    // Thermal trip only holds back the internal drive
    wire logic hold    = (ch == 0) & therm_off_r;               // see (R10)
    // Push-pull is powered whenever enabled and not thermally held, level picks the FET
    wire logic drv_req = en & ~hold & (is_pp | level);          // see (R05)
    wire logic [15:0] t1_cyc = 16'(t1 * T_UNIT_CYC);
    wire logic [15:0] t2_cyc = 16'((t2 + 3'h1) * T_UNIT_CYC);
    wire logic active  = (st_r[ch] == dopc_pkg::DOPC_T1) | (st_r[ch] == dopc_pkg::DOPC_NORM) |
                         (st_r[ch] == dopc_pkg::DOPC_T2);

    logic [15:0]           cnt_r;
    logic [15:0]           cnt_nxt;
    dopc_pkg::dopc_state_e st_nxt;
    logic                  sev;
    logic                  tev;

    assign int_en_w[ch] = en;
    assign short_ev[ch] = sev;
    assign tout_ev[ch]  = tev;

    // Protection sequencing: off, high-limit T1, normal, low-limit T2, timed out
    always_comb begin
      st_nxt  = st_r[ch];
      cnt_nxt = (cnt_r != 16'h0000) ? cnt_r - 16'h0001 : cnt_r;
      sev     = 1'b0;
      tev     = 1'b0;
      case (st_r[ch])
        dopc_pkg::DOPC_OFF: begin
          if (drv_req) begin
            if (is_pp || t1 == 3'h0) begin                      // see (R04) (R18)
              st_nxt = dopc_pkg::DOPC_NORM;
            end else begin
              st_nxt  = dopc_pkg::DOPC_T1;                      // see (R13) (R26)
              cnt_nxt = t1_cyc - 16'h0001;
            end
          end
        end
        dopc_pkg::DOPC_T1: begin
          // Shorts are ridden through at the high limit, silently
          if (!drv_req) begin
            st_nxt = dopc_pkg::DOPC_OFF;
          end else if (cnt_r == 16'h0000) begin
            st_nxt = dopc_pkg::DOPC_NORM;                       // see (R14)
          end
        end
        dopc_pkg::DOPC_NORM: begin
          if (!drv_req) begin
            st_nxt = dopc_pkg::DOPC_OFF;
          end else if (short_s[ch]) begin
            st_nxt  = dopc_pkg::DOPC_T2;                        // see (R15)
            cnt_nxt = t2_cyc - 16'h0001;
            sev     = 1'b1;                                     // see (R11) (R12)
          end
        end
        dopc_pkg::DOPC_T2: begin
          if (!drv_req) begin
            st_nxt = dopc_pkg::DOPC_OFF;
          end else if (!short_s[ch]) begin
            st_nxt = dopc_pkg::DOPC_NORM;
          end else if (cnt_r == 16'h0000) begin
            st_nxt = dopc_pkg::DOPC_TOUT;                       // see (R16)
            tev    = 1'b1;
          end
        end
        dopc_pkg::DOPC_TOUT: begin
          // Stays off until the level is taken low
          if (!level) begin
            st_nxt = dopc_pkg::DOPC_OFF;
          end
        end
        default: st_nxt = dopc_pkg::DOPC_OFF;
      endcase
    end

    // State, timer and drive outputs
    always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
        st_r[ch] <= dopc_pkg::DOPC_OFF;
        cnt_r    <= 16'h0000;
        drv_r[ch] <= 4'h0;
      end else begin
        st_r[ch] <= st_nxt;
        cnt_r    <= cnt_nxt;
        drv_r[ch] <= {active & is_srcd,                          // see (R01)
                      active & (is_src | is_snk) & (st_r[ch] == dopc_pkg::DOPC_T1), // see (R14)
                      active & (is_pp ? ~level : is_snk),       // see (R02) (R05)
                      active & (is_pp ? level : is_src)};
      end
    end

    // Configuration: a timeout clears the mode, winning over a same-cycle write
    always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
        cfg_r[ch]     <= dopc_pkg::CFG_RST;
        pin_cfg_r[ch] <= dopc_pkg::PIN_CFG_RST;
      end else begin
        if (tev) begin
          cfg_r[ch][dopc_pkg::CFG_MODE_LSB +: dopc_pkg::CFG_MODE_W] <= dopc_pkg::MODE_DIS; // see (R17)
        end else if (wr_cfg[ch]) begin
          cfg_r[ch] <= cfg_wr[dopc_pkg::CFG_W-1:0];
        end
        if (wr_pin[ch]) begin
          pin_cfg_r[ch] <= merge16(pin_cfg_r[ch], i_writedata[15:0], bmask);
        end
      end
    end
  end

  // Diagnostic slot routing: slots 0/1 external sink/source, 2/3 internal
  logic [3:0] sense_r;
  for (genvar s = 0; s < 4; s++) begin : g_diag
    always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
        sense_r[s] <= 1'b0;
      end else begin
        sense_r[s] <= conv_ctrl_r[s] & (diag_sel_r[4*s +: 4] == dopc_pkg::DIAG_SEL_CUR); // see (R20) (R22)
      end
    end
  end

  // Thermal trip latch, released at the cool point or on disable
  wire logic therm_nxt = int_en & (hot_s | (therm_off_r & ~cool_s));   // see (R09) (R10)

  // Sticky alerts: a new event beats a same-cycle write-one clear
  wire logic [dopc_pkg::ALERT_W-1:0] alert_ev = {tout_ev[1], tout_ev[0], short_ev[1], short_ev[0], therm_ev};
  wire logic [dopc_pkg::ALERT_W-1:0] alert_clr = wr_alert & i_byteenable[0] ?
                                                 i_writedata[dopc_pkg::ALERT_W-1:0] : 5'h00;
  wire logic [dopc_pkg::ALERT_W-1:0] alert_nxt = (alert_r & ~alert_clr) | alert_ev; // see (R27)

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      alert_r     <= 5'h00;
      therm_off_r <= 1'b0;
      o_alert_n   <= 1'b1;
      diag_sel_r  <= dopc_pkg::DIAG_SEL_RST;
      conv_ctrl_r <= dopc_pkg::CONV_CTRL_RST;
    end else begin
      alert_r     <= alert_nxt;
      therm_off_r <= therm_nxt;
      o_alert_n   <= ~|alert_nxt;                               // see (R27)
      if (wr_diag) begin
        diag_sel_r <= merge16(diag_sel_r, i_writedata[15:0], bmask);
      end
      if (wr_conv) begin
        conv_ctrl_r <= merge16(conv_ctrl_r, i_writedata[15:0], bmask);
      end
    end
  end

  // Read mux; unmapped addresses read zero
  wire logic [15:0] diag_res = i_diag_result[16*i_address[3:2] +: 16];
  wire logic [31:0] status_w = {21'h00_0000, therm_off_r, st_r[1], st_r[0]};
  wire logic [31:0] rd_mux =
    (i_address == dopc_pkg::ADDR_INT_CFG)    ? 32'(cfg_r[0]) :
    (i_address == dopc_pkg::ADDR_EXT_CFG)    ? 32'(cfg_r[1]) :
    (i_address == dopc_pkg::ADDR_PIN_CFG1)   ? 32'(pin_cfg_r[1]) :
    (i_address == dopc_pkg::ADDR_PIN_CFG2)   ? 32'(pin_cfg_r[0]) :
    (i_address == dopc_pkg::ADDR_ALERT)      ? 32'(alert_r) :
    (i_address == dopc_pkg::ADDR_DIAG_SEL)   ? 32'(diag_sel_r) :
    (i_address == dopc_pkg::ADDR_CONV_CTRL)  ? 32'(conv_ctrl_r) :
    (i_address == dopc_pkg::ADDR_STATE)      ? status_w :
    (i_address[5:4] == dopc_pkg::ADDR_RES_PAGE) ? 32'(diag_res) :   // see (R22)
                                               32'h0000_0000;

  // Bus slave: wait drops for one cycle per access, data captured with it
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wait_r <= ~(req & wait_r);
      if (i_read & wait_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign o_waitrequest      = wait_r;
  assign o_readdata         = rdata_r;
  assign o_int_src_on       = drv_r[0][0];
  assign o_int_snk_on       = drv_r[0][1];
  assign o_int_hi_limit     = drv_r[0][2];
  assign o_ext_src_on       = drv_r[1][0];
  assign o_ext_snk_on       = drv_r[1][1];
  assign o_ext_hi_limit     = drv_r[1][2];
  assign o_smart_diode_gate = drv_r[1][3];
  assign o_diag_cur_sense   = sense_r;

endmodule // dopc_ctrl

// ==== dopc_ctrl_checker.sv ====
/* Port checker for the protection controller.
   Assumes it is bound onto dopc_ctrl with the same unit parameter. */
`timescale 1ns/1ps
module dopc_ctrl_checker #(
  parameter int T_UNIT_CYC = 1000
) (
  input wire logic        i_ref_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_read,
  input wire logic        i_write,
  input wire logic        i_ext_short,
  input wire logic        i_therm_hot,
  input wire logic        i_therm_cool,
  input wire logic [31:0] o_readdata,
  input wire logic        o_waitrequest,
  input wire logic        o_int_src_on,
  input wire logic        o_int_snk_on,
  input wire logic        o_int_hi_limit,
  input wire logic        o_ext_src_on,
  input wire logic        o_ext_snk_on,
  input wire logic        o_smart_diode_gate,
  input wire logic        o_alert_n
);
  // Longest T1 plus T2 plus sync slack
  localparam int SC_LIMIT = 15 * T_UNIT_CYC + 8;
  logic [15:0] sc_cnt_r;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // Only counts while the FET conducts, so a recovery restarts it
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || !i_ext_short || !(o_ext_src_on || o_ext_snk_on))
      sc_cnt_r <= 16'h0000;
    else
      sc_cnt_r <= sc_cnt_r + 16'h0001;
  end
  sequence s_taken;
    (i_read || i_write) && o_waitrequest;
  endsequence
  sequence s_hot;
    (i_therm_hot && !i_therm_cool) [*6];
  endsequence
  AST_BUS_ANSWER: assert property (s_taken |=> !o_waitrequest ##1 o_waitrequest)
    else $error("bus answer not one cycle");
  AST_BUS_IDLE: assert property (!(i_read || i_write) |=> o_waitrequest)
    else $error("answer without request");
  AST_RD_UPPER: assert property (!o_waitrequest |-> o_readdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  AST_RST_QUIET: assert property ($past(i_sys_rst) |-> o_waitrequest && o_alert_n && !o_int_src_on
                                  && !o_ext_src_on && !o_smart_diode_gate)
    else $error("outputs active after reset");
  AST_INT_NO_SHOOT: assert property (!(o_int_src_on && o_int_snk_on))
    else $error("internal source and sink both on");
  AST_EXT_NO_SHOOT: assert property (!(o_ext_src_on && o_ext_snk_on))
    else $error("external source and sink both on");
  AST_INT_HI_ON: assert property (o_int_hi_limit |-> o_int_src_on || o_int_snk_on)
    else $error("high limit with FET off");
  AST_DIODE_SRC: assert property (o_smart_diode_gate |-> o_ext_src_on && !o_ext_snk_on)
    else $error("diode gate without sourcing");
  AST_THERM_OFF: assert property (s_hot |-> !o_int_src_on && !o_int_snk_on)
    else $error("internal drive on while hot");
  AST_EXT_TIMEOUT: assert property (sc_cnt_r <= SC_LIMIT)
    else $error("external short not timed out");
endmodule // dopc_ctrl_checker

bind dopc_ctrl dopc_ctrl_checker #(.T_UNIT_CYC(T_UNIT_CYC)) chk_u (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_read(i_read), .i_write(i_write),
  .i_ext_short(i_ext_short), .i_therm_hot(i_therm_hot), .i_therm_cool(i_therm_cool),
  .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_int_src_on(o_int_src_on),
  .o_int_snk_on(o_int_snk_on), .o_int_hi_limit(o_int_hi_limit), .o_ext_src_on(o_ext_src_on),
  .o_ext_snk_on(o_ext_snk_on), .o_smart_diode_gate(o_smart_diode_gate), .o_alert_n(o_alert_n));

// ==== dopc_ctrl_test.sv ====
/* Testbench of the protection controller.
   Assumes dopc_pkg, dopc_ctrl, the checker and the load model are compiled first. */
`timescale 1ns/1ps
module dopc_ctrl_test;
  logic ref_clk = 1'b0, sys_rst = 1'b1, rd = 1'b0, wr = 1'b0, wait_rq, alert_n, gate;
  logic [5:0] addr = 6'h00, a, pa;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic int_pin = 1'b0, ext_pin = 1'b0, hot = 1'b0, cool = 1'b0, int_flt = 1'b0, ext_flt = 1'b0;
  logic int_sc, ext_sc, int_src, int_snk, int_hi, ext_src, ext_snk, ext_hi;
  logic [63:0] diag = 64'hD3C4_B2A1_9081_7060;
  logic [3:0] sense;
  logic [2:0] m, t1;
  int fail_count = 0, checks = 0, cyc = 0, n;
  // Short unit keeps the timer walks brief
  dopc_ctrl #(.T_UNIT_CYC(4)) dut_u (
    .i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_address(addr), .i_read(rd), .i_write(wr),
    .i_writedata(wdata), .i_byteenable(4'hF), .o_readdata(rdata), .o_waitrequest(wait_rq),
    .i_int_ctrl_pin(int_pin), .i_ext_ctrl_pin(ext_pin), .i_int_short(int_sc), .i_ext_short(ext_sc),
    .i_therm_hot(hot), .i_therm_cool(cool), .i_diag_result(diag), .o_int_src_on(int_src),
    .o_int_snk_on(int_snk), .o_int_hi_limit(int_hi), .o_ext_src_on(ext_src), .o_ext_snk_on(ext_snk),
    .o_ext_hi_limit(ext_hi), .o_smart_diode_gate(gate), .o_alert_n(alert_n), .o_diag_cur_sense(sense));
  dopc_load_model load_u (
    .i_int_src_on(int_src), .i_int_snk_on(int_snk), .i_ext_src_on(ext_src), .i_ext_snk_on(ext_snk),
    .i_int_fault(int_flt), .i_ext_fault(ext_flt), .o_int_short(int_sc), .o_ext_short(ext_sc));
  // Clock and hang guard
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic final_report();
    if (fail_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic fail(input string s);
    fail_count++;
    $display("[FAIL] %0t %s", $time, s);
  endtask
  task automatic cmp(input logic [31:0] g, e, input string s);
    checks++;
    if (g !== e) fail(s);
  endtask
  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [5:0] ad, input logic [15:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge ref_clk);
    wr <= w;
    rd <= !w;
    addr <= ad;
    wdata <= {16'h0000, d};
    do begin
      @(posedge ref_clk);
      k++;
    end while (wait_rq !== 1'b0 && k < 20);
    if (k >= 20) fail("bus hang");
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wreg(input logic [5:0] ad, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, ad, d, q);
  endtask
  task automatic rreg(input logic [5:0] ad, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, ad, 16'h0000, q);
    cmp(q, e, "read data");
  endtask
  // Waits for {src, snk, hi}; optionally flags any high-limit cycle
  task automatic wait_drv(input bit ext, input logic [2:0] e, input bit no_hi);
    logic [2:0] g;
    for (int k = 0; k < 80; k++) begin
      @(posedge ref_clk);
      g = ext ? {ext_src, ext_snk, ext_hi} : {int_src, int_snk, int_hi};
      if (no_hi && g[0] !== 1'b0) fail("high limit in push-pull");
      if (g === e) break;
    end
    cmp({29'h0, g}, {29'h0, e}, "drive state");
  endtask
  task automatic wait_sense(input logic [3:0] e);
    for (int k = 0; k < 20 && sense !== e; k++) @(posedge ref_clk);
    cmp({28'h0, sense}, {28'h0, e}, "sense slots");
  endtask
  function automatic logic [15:0] cfg(input logic [2:0] md, input logic s, d, input logic [2:0] x, y);
    return {5'h00, y, x, d, s, md};
  endfunction
  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // Reset values and an unmapped word
    for (int i = 0; i < 8; i++) rreg(6'(i * 4), (i == 7) ? 32'h0000_0021 : 32'h0000_0000);
    wreg(6'h30, 16'hFFFF);
    rreg(6'h30, 32'h0000_0000);
    // Every drive kind on both outputs, disabled in between
    for (int j = 0; j < 2; j++) begin
      for (int i = 1; i < (j ? 5 : 4); i++) begin
        m = 3'(i);
        t1 = (m == dopc_pkg::MODE_PP) ? 3'h3 : 3'h0;
        a = j ? dopc_pkg::ADDR_EXT_CFG : dopc_pkg::ADDR_INT_CFG;
        wreg(a, cfg(m, 1'b0, 1'b0, t1, 3'h0));
        wreg(a, cfg(m, 1'b0, 1'b1, t1, 3'h0));
        wait_drv(j == 1, (m == dopc_pkg::MODE_SNK) ? 3'b010 : 3'b100, m == dopc_pkg::MODE_PP);
        @(posedge ref_clk);
        cmp({31'h0, gate}, {31'h0, j == 1 && m == dopc_pkg::MODE_SRC_D}, "diode gate");
        wreg(a, cfg(m, 1'b0, 1'b0, t1, 3'h0));
        wait_drv(j == 1, (m == dopc_pkg::MODE_PP) ? 3'b010 : 3'b000, m == dopc_pkg::MODE_PP);
        wreg(a, cfg(dopc_pkg::MODE_DIS, 1'b0, 1'b0, 3'h0, 3'h0));
        wait_drv(j == 1, 3'b000, 1'b0);
      end
    end
    // Level from the control pins
    for (int j = 0; j < 2; j++) begin
      a = j ? dopc_pkg::ADDR_EXT_CFG : dopc_pkg::ADDR_INT_CFG;
      pa = j ? dopc_pkg::ADDR_PIN_CFG1 : dopc_pkg::ADDR_PIN_CFG2;
      wreg(a, cfg(dopc_pkg::MODE_SRC, 1'b1, 1'b0, 3'h0, 3'h0));
      int_pin <= (j == 0);
      ext_pin <= (j == 1);
      repeat (8) @(posedge ref_clk);
      wait_drv(j == 1, 3'b000, 1'b0);
      wreg(pa, dopc_pkg::PIN_CFG_LEVEL);
      wait_drv(j == 1, 3'b100, 1'b0);
      int_pin <= 1'b0;
      ext_pin <= 1'b0;
      wait_drv(j == 1, 3'b000, 1'b0);
      wreg(pa, 16'h0000);
      wreg(a, 16'h0000);
    end
    // Internal short through T1, T2 and timeout, then recovery
    wreg(dopc_pkg::ADDR_INT_CFG, cfg(dopc_pkg::MODE_SRC, 1'b0, 1'b0, 3'h2, 3'h1));
    wreg(dopc_pkg::ADDR_INT_CFG, cfg(dopc_pkg::MODE_SRC, 1'b0, 1'b1, 3'h2, 3'h1));
    wait_drv(1'b0, 3'b101, 1'b0);
    int_flt <= 1'b1;
    for (n = 0; n < 40 && int_hi === 1'b1; n++) begin
      cmp({31'h0, alert_n}, 32'h0000_0001, "alert during high limit");
      @(posedge ref_clk);
    end
    cmp({31'h0, int_src}, 32'h0000_0001, "FET off at low limit");
    wait_drv(1'b0, 3'b000, 1'b0);
    cmp({31'h0, alert_n}, 32'h0000_0000, "alert pin idle");
    rreg(dopc_pkg::ADDR_ALERT, 32'h0000_000A);
    rreg(dopc_pkg::ADDR_INT_CFG, {16'h0000, cfg(dopc_pkg::MODE_DIS, 1'b0, 1'b1, 3'h2, 3'h1)});
    int_flt <= 1'b0;
    wreg(dopc_pkg::ADDR_ALERT, 16'h0002);
    rreg(dopc_pkg::ADDR_ALERT, 32'h0000_0008);
    wreg(dopc_pkg::ADDR_ALERT, 16'h0008);
    rreg(dopc_pkg::ADDR_ALERT, 32'h0000_0000);
    cmp({31'h0, alert_n}, 32'h0000_0001, "alert pin stuck");
    wreg(dopc_pkg::ADDR_INT_CFG, cfg(dopc_pkg::MODE_SRC, 1'b0, 1'b0, 3'h0, 3'h0));
    wreg(dopc_pkg::ADDR_INT_CFG, cfg(dopc_pkg::MODE_SRC, 1'b0, 1'b1, 3'h0, 3'h0));
    wait_drv(1'b0, 3'b100, 1'b0);
    // Thermal shutdown and automatic restart
    hot <= 1'b1;
    wait_drv(1'b0, 3'b000, 1'b0);
    rreg(dopc_pkg::ADDR_ALERT, 32'h0000_0001);
    hot <= 1'b0;
    cool <= 1'b1;
    wait_drv(1'b0, 3'b100, 1'b0);
    cool <= 1'b0;
    wreg(dopc_pkg::ADDR_ALERT, 16'h001F);
    wreg(dopc_pkg::ADDR_INT_CFG, 16'h0000);
    // External smart-diode short times out
    wreg(dopc_pkg::ADDR_EXT_CFG, cfg(dopc_pkg::MODE_SRC_D, 1'b0, 1'b0, 3'h1, 3'h0));
    wreg(dopc_pkg::ADDR_EXT_CFG, cfg(dopc_pkg::MODE_SRC_D, 1'b0, 1'b1, 3'h1, 3'h0));
    wait_drv(1'b1, 3'b101, 1'b0);
    ext_flt <= 1'b1;
    wait_drv(1'b1, 3'b000, 1'b0);
    rreg(dopc_pkg::ADDR_ALERT, 32'h0000_0014);
    rreg(dopc_pkg::ADDR_EXT_CFG, {16'h0000, cfg(dopc_pkg::MODE_DIS, 1'b0, 1'b1, 3'h1, 3'h0)});
    ext_flt <= 1'b0;
    wreg(dopc_pkg::ADDR_ALERT, 16'h001F);
    rreg(dopc_pkg::ADDR_ALERT, 32'h0000_0000);
    // Current-sense slots; slots 1 and 3 first, then slots 0 and 2 selected in their place
    wreg(dopc_pkg::ADDR_DIAG_SEL, 16'h5050);
    wreg(dopc_pkg::ADDR_CONV_CTRL, 16'h000F);
    wait_sense(4'hA);
    wreg(dopc_pkg::ADDR_CONV_CTRL, 16'h0003);
    wait_sense(4'h2);
    wreg(dopc_pkg::ADDR_DIAG_SEL, 16'h0505);
    wait_sense(4'h1);
    rreg(6'h28, 32'h0000_B2A1);
    final_report();
  end
endmodule // dopc_ctrl_test

// ==== dopc_load_model.sv ====
/* FETs and field load model.
   Assumes the bench commands when the load is shorted. */
`timescale 1ns/1ps
module dopc_load_model (
  input  wire logic i_int_src_on,
  input  wire logic i_int_snk_on,
  input  wire logic i_ext_src_on,
  input  wire logic i_ext_snk_on,
  input  wire logic i_int_fault,
  input  wire logic i_ext_fault,
  output logic      o_int_short,
  output logic      o_ext_short
);
  // A shorted load only trips the comparator while its FET conducts
  assign o_int_short = i_int_fault && (i_int_src_on || i_int_snk_on);
  assign o_ext_short = i_ext_fault && (i_ext_src_on || i_ext_snk_on);
endmodule // dopc_load_model

// ==== dopc_pkg.sv ====
/*
  Package for the digital output protection controller: register map, field layout,
  reset values, drive kinds, protection state codes and timing figures.
  Assumes a 100 MHz core clock and a 32-bit Avalon-MM register port.
*/
package dopc_pkg;

  // Register byte addresses, one aligned word each
  localparam logic [5:0] ADDR_INT_CFG   = 6'h00;
  localparam logic [5:0] ADDR_EXT_CFG   = 6'h04;
  localparam logic [5:0] ADDR_PIN_CFG1  = 6'h08;
  localparam logic [5:0] ADDR_PIN_CFG2  = 6'h0C;
  localparam logic [5:0] ADDR_ALERT     = 6'h10;
  localparam logic [5:0] ADDR_DIAG_SEL  = 6'h14;
  localparam logic [5:0] ADDR_CONV_CTRL = 6'h18;
  localparam logic [5:0] ADDR_STATE     = 6'h1C;
  localparam logic [1:0] ADDR_RES_PAGE  = 2'h2;   // 0x20..0x2C, one result per slot

  // Output configuration word, same layout for the internal and the external drive
  localparam int CFG_W        = 11;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_MODE_W   = 3;
  localparam int CFG_SRC_BIT  = 3;
  localparam int CFG_DATA_BIT = 4;
  localparam int CFG_T1_LSB   = 5;
  localparam int CFG_T2_LSB   = 8;
  localparam int CFG_T_W      = 3;
  localparam logic [CFG_W-1:0] CFG_RST = 11'h000;

  // Drive kinds held in the mode field
  localparam logic [2:0] MODE_DIS   = 3'h0;
  localparam logic [2:0] MODE_SRC   = 3'h1;
  localparam logic [2:0] MODE_SNK   = 3'h2;
  localparam logic [2:0] MODE_PP    = 3'h3;
  localparam logic [2:0] MODE_SRC_D = 3'h4;    // Source with smart diode, external only

  // Pin configuration
  localparam logic [15:0] PIN_CFG_RST   = 16'h0000;
  localparam logic [15:0] PIN_CFG_LEVEL = 16'h0004;

  // Alert status bit positions
  localparam int ALERT_W      = 5;
  localparam int ALERT_THERM  = 0;
  localparam int ALERT_INT_SC = 1;
  localparam int ALERT_EXT_SC = 2;
  localparam int ALERT_INT_TO = 3;
  localparam int ALERT_EXT_TO = 4;

  // Diagnostics
  localparam logic [15:0] DIAG_SEL_RST  = 16'h0000;
  localparam logic [3:0]  DIAG_SEL_CUR  = 4'h5;  // Slot measures output current
  localparam logic [15:0] CONV_CTRL_RST = 16'h0000;

  // Protection timer unit
  localparam int CLK_MHZ    = 100;
  localparam int T_UNIT_US  = 10;
  localparam int T_UNIT_CYC = T_UNIT_US * CLK_MHZ;

  typedef enum logic [4:0] {
    DOPC_OFF  = 5'h01,
    DOPC_T1   = 5'h02,
    DOPC_NORM = 5'h04,
    DOPC_T2   = 5'h08,
    DOPC_TOUT = 5'h10
  } dopc_state_e;

endpackage
